/* atcs_consts.vh */
// Register offsets, field layout, reset values and timing constants of the transmit channel slot block
`ifndef ATCS_CONSTS_VH
`define ATCS_CONSTS_VH

// ----------------------------------------
// Register indices and address width
// ----------------------------------------
`define ATCS_IDX_CH5 8'h22
`define ATCS_IDX_CH6 8'h23
`define ATCS_IDX_CH7 8'h24
`define ATCS_IDX_ROUTE 8'h30
`define ATCS_IDX_FORMAT 8'h31
`define ATCS_IDX_STATUS 8'h32
`define ATCS_ADDR_W 10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ATCS_RSV_BIT 7
`define ATCS_SRC_HI 6
`define ATCS_SRC_LO 5
`define ATCS_SLOT_HI 4
`define ATCS_SLOT_LO 0

// ----------------------------------------
// Source select encodings
// ----------------------------------------
`define ATCS_SRC_HIZ 2'h0
`define ATCS_SRC_LOOP 2'h1
`define ATCS_SRC_ECHO 2'h2
`define ATCS_SRC_RSV 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ATCS_RST_CH5 8'h04
`define ATCS_RST_CH6 8'h05
`define ATCS_RST_CH7 8'h06
`define ATCS_RST_ROUTE 3'h0
`define ATCS_RST_FORMAT 1'h0

// ----------------------------------------
// Serial frame constants
// ----------------------------------------
`define ATCS_WORD_LEN 32
`define ATCS_SLOTS_PER_HALF 16

`endif

/* atcs_sync.v */
// Two flip-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module atcs_sync #(
    parameter WIDTH = 1
) (
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta;

    // ----------------------------------------
    // Synchroniser stages
    // ----------------------------------------
    // First stage feeds only the second stage
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta <= {WIDTH{1'b0}};
            sync_o <= {WIDTH{1'b0}};
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule

/* atcs_tx_slots.v */
// Transmit channels 5 to 7: source select, slot assignment, pin routing and APB registers
//
// What this block does
// - Bit 7 of each channel register is reserved and always reads zero.
// - Channel 5 source: 0 high impedance, 1 input 1 loopback, 2 echo 1, 3 reserved.
// - Channel 5 source resets to zero, output high impedance until software selects.
// - Channel 6 source: 0 high impedance, 1 input 2 loopback, 2 echo 2; resets zero.
// - Channel 7 source 1 sends battery half word then temperature half word.
// - Channel 7 source 2 sends echo 1 half word then echo 2 half word.
// - Slot field maps to TDM slot; I2S/LJ: 0-15 left, 16-31 right slots.
// - Channel 5 register at 0x22 resets to 0x04, slot four.
// - Channel 6 register at 0x23 resets to 0x05, slot five.
// - Channel 7 register at 0x24 resets to 0x06, slot six.
// - Per-channel route bit: 0 primary data pin, 1 secondary data pin.
`timescale 1ns/1ps
`include "atcs_consts.vh"
module atcs_tx_slots #(
    parameter WORD_LEN = `ATCS_WORD_LEN
) (
    input wire clk_i,
    input wire rst_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [`ATCS_ADDR_W-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // Serial link pins, from the far side
    input wire bit_clk_i,
    input wire frame_sync_i,
    // Sample sources from the device datapath
    input wire [WORD_LEN-1:0] loop_first_i,
    input wire [WORD_LEN-1:0] loop_second_i,
    input wire [WORD_LEN-1:0] echo_reference_first_i,
    input wire [WORD_LEN-1:0] echo_reference_second_i,
    input wire [WORD_LEN/2-1:0] battery_level_half_word_i,
    input wire [WORD_LEN/2-1:0] temperature_half_word_i,
    // Data output pins, two signals each
    output reg serial_out_pin_a_o,
    output reg serial_out_pin_a_oe_o,
    output reg serial_out_pin_b_o,
    output reg serial_out_pin_b_oe_o
);
    localparam CW = 5;

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg [1:0] ch5_source_select;
    reg [1:0] ch6_source_select;
    reg [1:0] ch7_source_select;
    reg [4:0] ch5_slot_number;
    reg [4:0] ch6_slot_number;
    reg [4:0] ch7_slot_number;
    reg [2:0] pin_route;
    reg lr_format;

    // ----------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------
    wire [1:0] pins_sync;
    reg bclk_d;
    reg fsync_d;

    atcs_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({frame_sync_i, bit_clk_i}),
        .sync_o(pins_sync)
    );

    wire bclk_s = pins_sync[0];
    wire fsync_s = pins_sync[1];
    wire bclk_fall = bclk_d & ~bclk_s;
    wire fsync_rise = fsync_s & ~fsync_d;
    wire fsync_fall = ~fsync_s & fsync_d;

    always @(posedge clk_i) begin
        if (rst_i) begin
            bclk_d <= 1'b0;
            fsync_d <= 1'b0;
        end else begin
            bclk_d <= bclk_s;
            fsync_d <= fsync_s;
        end
    end

    // ----------------------------------------
    // APB register access
    // ----------------------------------------
    wire [7:0] reg_idx = paddr_i[`ATCS_ADDR_W-1:2];
    wire apb_access = psel_i & penable_i & ~pready_o;
    wire idx_ok = (reg_idx == `ATCS_IDX_CH5) || (reg_idx == `ATCS_IDX_CH6) || (reg_idx == `ATCS_IDX_CH7) ||
                  (reg_idx == `ATCS_IDX_ROUTE) || (reg_idx == `ATCS_IDX_FORMAT) ||
                  (reg_idx == `ATCS_IDX_STATUS) || (paddr_i[1:0] != 2'b00);
    wire map_hit = idx_ok && (paddr_i[1:0] == 2'b00);
    wire [7:0] rst_ch5 = `ATCS_RST_CH5;
    wire [7:0] rst_ch6 = `ATCS_RST_CH6;
    wire [7:0] rst_ch7 = `ATCS_RST_CH7;
    reg [31:0] next_prdata;
    reg [4:0] slot_count;
    reg half_right;

    // Read mux; reserved bit 7 is never stored so it reads zero
    always @* begin
        next_prdata = 32'h0000_0000;
        case (reg_idx)
            `ATCS_IDX_CH5: next_prdata = {24'h00_0000, 1'b0, ch5_source_select, ch5_slot_number};
            `ATCS_IDX_CH6: next_prdata = {24'h00_0000, 1'b0, ch6_source_select, ch6_slot_number};
            `ATCS_IDX_CH7: next_prdata = {24'h00_0000, 1'b0, ch7_source_select, ch7_slot_number};
            `ATCS_IDX_ROUTE: next_prdata = {29'h0000_0000, pin_route};
            `ATCS_IDX_FORMAT: next_prdata = {31'h0000_0000, lr_format};
            `ATCS_IDX_STATUS: next_prdata = {24'h00_0000, serial_out_pin_b_oe_o, serial_out_pin_a_oe_o,
                                             half_right, slot_count};
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    // One wait state: ready answers in the second access cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= apb_access;
            pslverr_o <= apb_access & ~map_hit;
            prdata_o <= (apb_access & ~pwrite_i & map_hit) ? next_prdata : 32'h0000_0000;
        end
    end

    // Writes land in the cycle pready is seen high
    wire wr_en = psel_i & penable_i & pready_o & pwrite_i & map_hit;

    always @(posedge clk_i) begin
        if (rst_i) begin
            ch5_source_select <= rst_ch5[`ATCS_SRC_HI:`ATCS_SRC_LO];
            ch5_slot_number <= rst_ch5[`ATCS_SLOT_HI:`ATCS_SLOT_LO];
            ch6_source_select <= rst_ch6[`ATCS_SRC_HI:`ATCS_SRC_LO];
            ch6_slot_number <= rst_ch6[`ATCS_SLOT_HI:`ATCS_SLOT_LO];
            ch7_source_select <= rst_ch7[`ATCS_SRC_HI:`ATCS_SRC_LO];
            ch7_slot_number <= rst_ch7[`ATCS_SLOT_HI:`ATCS_SLOT_LO];
            pin_route <= `ATCS_RST_ROUTE;
            lr_format <= `ATCS_RST_FORMAT;
        end else if (wr_en) begin
            case (reg_idx)
                `ATCS_IDX_CH5: begin
                    ch5_source_select <= pwdata_i[`ATCS_SRC_HI:`ATCS_SRC_LO];
                    ch5_slot_number <= pwdata_i[`ATCS_SLOT_HI:`ATCS_SLOT_LO];
                end
                `ATCS_IDX_CH6: begin
                    ch6_source_select <= pwdata_i[`ATCS_SRC_HI:`ATCS_SRC_LO];
                    ch6_slot_number <= pwdata_i[`ATCS_SLOT_HI:`ATCS_SLOT_LO];
                end
                `ATCS_IDX_CH7: begin
                    ch7_source_select <= pwdata_i[`ATCS_SRC_HI:`ATCS_SRC_LO];
                    ch7_slot_number <= pwdata_i[`ATCS_SLOT_HI:`ATCS_SLOT_LO];
                end
                `ATCS_IDX_ROUTE: pin_route <= pwdata_i[2:0];
                `ATCS_IDX_FORMAT: lr_format <= pwdata_i[0];
                default: pin_route <= pin_route;
            endcase
        end
    end

    // ----------------------------------------
    // Frame and slot tracking
    // ----------------------------------------
    // Bit and slot counters advance on bit clock falling edges (launch edge).
    // TDM: frame sync rise restarts slot 0. I2S/LJ: sync level picks left or right.
    localparam integer LAST_BIT_FULL = WORD_LEN - 1;
    localparam [CW-1:0] LAST_BIT = LAST_BIT_FULL[CW-1:0];
    reg [CW-1:0] bit_count;
    reg frame_seen;
    reg [WORD_LEN-1:0] shift_word;
    wire slot_end = (bit_count == LAST_BIT);
    wire [4:0] next_slot = slot_end ? slot_count + 5'd1 : slot_count;
    wire lr_edge = fsync_rise | fsync_fall;
    wire restart = lr_format ? lr_edge : fsync_rise;
    wire [4:0] next_slot_r = restart ? 5'd0 : next_slot;
    wire next_right = lr_format & (restart ? fsync_s : half_right);
    // Effective slot index: right half offsets by sixteen
    wire [4:0] slot_eff = lr_format ? {next_right, next_slot_r[3:0]} : next_slot_r;

    wire own5 = (ch5_source_select == `ATCS_SRC_LOOP) || (ch5_source_select == `ATCS_SRC_ECHO);
    wire own6 = (ch6_source_select == `ATCS_SRC_LOOP) || (ch6_source_select == `ATCS_SRC_ECHO);
    wire own7 = (ch7_source_select == `ATCS_SRC_LOOP) || (ch7_source_select == `ATCS_SRC_ECHO);
    // Reserved and zero settings never own a slot, so the pin stays released
    wire hit5 = own5 && (ch5_slot_number == slot_eff);
    wire hit6 = own6 && (ch6_slot_number == slot_eff);
    wire hit7 = own7 && (ch7_slot_number == slot_eff);

    // Source mux, lowest channel wins when two claim the same slot
    reg [WORD_LEN-1:0] next_word;
    reg next_pin_b;
    reg next_drive;
    always @* begin
        next_word = {WORD_LEN{1'b0}};
        next_pin_b = 1'b0;
        next_drive = 1'b0;
        if (hit5) begin
            next_drive = 1'b1;
            next_pin_b = pin_route[0];
            next_word = (ch5_source_select == `ATCS_SRC_LOOP) ? loop_first_i : echo_reference_first_i;
        end else if (hit6) begin
            next_drive = 1'b1;
            next_pin_b = pin_route[1];
            next_word = (ch6_source_select == `ATCS_SRC_LOOP) ? loop_second_i : echo_reference_second_i;
        end else if (hit7) begin
            next_drive = 1'b1;
            next_pin_b = pin_route[2];
            if (ch7_source_select == `ATCS_SRC_LOOP) begin
                next_word = {battery_level_half_word_i, temperature_half_word_i};
            end else begin
                next_word = {echo_reference_first_i[WORD_LEN-1:WORD_LEN/2],
                             echo_reference_second_i[WORD_LEN-1:WORD_LEN/2]};
            end
        end
    end

    // ----------------------------------------
    // Serialiser and pin drive
    // ----------------------------------------
    // Nothing drives until the first frame sync; a stray bit clock alone cannot launch data
    always @(posedge clk_i) begin
        if (rst_i) begin
            bit_count <= {CW{1'b0}};
            slot_count <= 5'd0;
            half_right <= 1'b0;
            frame_seen <= 1'b0;
            shift_word <= {WORD_LEN{1'b0}};
            serial_out_pin_a_o <= 1'b0;
            serial_out_pin_a_oe_o <= 1'b0;
            serial_out_pin_b_o <= 1'b0;
            serial_out_pin_b_oe_o <= 1'b0;
        end else if (bclk_fall) begin
            if (restart | slot_end) begin
                bit_count <= {CW{1'b0}};
                slot_count <= next_slot_r;
                half_right <= next_right;
                frame_seen <= frame_seen | restart;
                shift_word <= {next_word[WORD_LEN-2:0], 1'b0};
                serial_out_pin_a_o <= next_word[WORD_LEN-1];
                serial_out_pin_b_o <= next_word[WORD_LEN-1];
                serial_out_pin_a_oe_o <= (frame_seen | restart) & next_drive & ~next_pin_b;
                serial_out_pin_b_oe_o <= (frame_seen | restart) & next_drive & next_pin_b;
            end else begin
                bit_count <= bit_count + {{(CW-1){1'b0}}, 1'b1};
                shift_word <= {shift_word[WORD_LEN-2:0], 1'b0};
                serial_out_pin_a_o <= shift_word[WORD_LEN-1];
                serial_out_pin_b_o <= shift_word[WORD_LEN-1];
            end
        end
    end
endmodule

/* atcs_tx_slots_properties.sv */
// Port checker of the transmit channel slot block, bound to its top
`timescale 1ns/1ps
`include "atcs_consts.vh"
module atcs_tx_slots_chk (
    input wire clk_i,
    input wire rst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [`ATCS_ADDR_W-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire bit_clk_i,
    input wire serial_out_pin_a_o,
    input wire serial_out_pin_a_oe_o,
    input wire serial_out_pin_b_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [2:0] route;
    logic written, bclk_q;
    logic [3:0] since_fall;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Raw bit clock sampled here, so the window allows for the design's synchroniser
    always @(posedge clk_i) begin
        if (rst_i) begin
            route <= 3'h0;
            written <= 1'b0;
            since_fall <= 4'hF;
            bclk_q <= 1'b1;
        end else begin
            bclk_q <= bit_clk_i;
            since_fall <= (bclk_q && !bit_clk_i) ? 4'h0 : since_fall + {3'h0, since_fall != 4'hF};
            // Only a channel register write can select a source
            written <= written || (pready_o && pwrite_i && !pslverr_o && paddr_i inside {10'h088, 10'h08C, 10'h090});
            if (pready_o && pwrite_i && paddr_i == 10'h0C0) route <= pwdata_i[2:0];
        end
    end
    sequence s_access;
        psel_i && penable_i && !pready_o;
    endsequence
    sequence s_answer;
        pready_o ##1 !pready_o;
    endsequence
    a_ready_one_wait: assert property (s_access |=> s_answer)
        else $error("no single answer after access");
    a_err_misalign: assert property (pready_o && paddr_i[1:0] != 2'h0 |-> pslverr_o && prdata_o == 32'h0)
        else $error("misaligned access not refused");
    a_map_clean: assert property (pready_o && paddr_i inside {10'h088, 10'h08C, 10'h090}
        |-> !pslverr_o && prdata_o[31:7] == 25'h0) else $error("channel register answer bad");
    a_idle_quiet: assert property (!pready_o |-> !pslverr_o && prdata_o == 32'h0)
        else $error("answer outside access");
    a_reset_release: assert property ($fell(rst_i) |-> (!serial_out_pin_a_oe_o && !serial_out_pin_b_oe_o) [*4])
        else $error("pins driven after reset");
    a_hiz_until_set: assert property (!written |-> !serial_out_pin_a_oe_o && !serial_out_pin_b_oe_o)
        else $error("pins driven before setup");
    a_edge_aligned: assert property (serial_out_pin_a_oe_o && $past(serial_out_pin_a_oe_o)
        && $changed(serial_out_pin_a_o) |-> since_fall inside {[4'h1:4'h6]}) else $error("bit changed off edge");
    a_pin_b_route: assert property (route == 3'h0 |-> !serial_out_pin_b_oe_o)
        else $error("pin b driven with no route");
endmodule
bind atcs_tx_slots atcs_tx_slots_chk i_chk (.*);

/* atcs_host_model.sv */
// Host side of the link: bit clock, frame sync and capture of both data pins
`timescale 1ns/1ps
module atcs_host_model (
    input wire pin_a_i,
    input wire pin_a_oe_i,
    input wire pin_b_i,
    input wire pin_b_oe_i,
    output reg bit_clk_o = 1'b1,
    output reg frame_sync_o = 1'b0,
    output reg [32:0] res_a_o = 33'h0,
    output reg [32:0] res_b_o = 33'h0,
    output reg slot_done_o = 1'b0
);
    logic [32:0] acc_a, acc_b;
    logic line_a = 1'b0;
    logic line_b = 1'b0;
    // One frame of 32 slots; clock stands high between frames, long low phase before sampling
    task automatic run_frame(input logic i2s);
        for (int k = 0; k < 1024; k++) begin
            // Sync moves with the falling edge, the only place the device looks for it
            #20 frame_sync_o = i2s ? k >= 512 : k == 0;
            bit_clk_o = 1'b0;
            #60 bit_clk_o = 1'b1;
            // A released line must not keep its last value
            line_a = pin_a_oe_i ? pin_a_i : !line_a;
            line_b = pin_b_oe_i ? pin_b_i : !line_b;
            acc_a = {(k % 32 == 0 || acc_a[32]) && pin_a_oe_i, acc_a[30:0], line_a};
            acc_b = {(k % 32 == 0 || acc_b[32]) && pin_b_oe_i, acc_b[30:0], line_b};
            if (k % 32 == 31) begin
                res_a_o = acc_a[32] ? acc_a : 33'h0;
                res_b_o = acc_b[32] ? acc_b : 33'h0;
                slot_done_o = !slot_done_o;
            end
        end
    endtask
endmodule

/* test_atcs_tx_slots.sv */
// Self-checking bench of the transmit channel slot block
`timescale 1ns/1ps
module test_atcs_tx_slots;
    logic clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, watching = 1'b0;
    logic [9:0] paddr = 10'h0;
    logic [31:0] pwdata = 32'h0, loop1 = 32'h0, loop2 = 32'h0, echo1 = 32'h0, echo2 = 32'h0, prdata;
    logic [15:0] bat = 16'h0, temp = 16'h0;
    logic pready, pslverr, bclk, fsync, pa, pa_oe, pb, pb_oe, done;
    logic [32:0] res_a, res_b, exp_q [$];
    logic [31:0] mir [0:255] = '{default: 32'h0};
    logic [7:0] idx_t [5] = '{8'h31, 8'h30, 8'h22, 8'h23, 8'h24};
    logic [7:0] cfg_t [4][5] = '{'{default: 8'h0}, '{8'h0, 8'h2, 8'hA0, 8'h5F, 8'h25},
        '{8'h0, 8'h4, 8'h67, 8'h08, 8'h46}, '{8'h1, 8'h1, 8'h50, 8'h2F, 8'h20}};
    int failures = 0, tests_run = 0;
    atcs_tx_slots i_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .bit_clk_i(bclk), .frame_sync_i(fsync), .loop_first_i(loop1), .loop_second_i(loop2),
        .echo_reference_first_i(echo1), .echo_reference_second_i(echo2), .battery_level_half_word_i(bat),
        .temperature_half_word_i(temp), .serial_out_pin_a_o(pa), .serial_out_pin_a_oe_o(pa_oe),
        .serial_out_pin_b_o(pb), .serial_out_pin_b_oe_o(pb_oe));
    atcs_host_model i_host (.pin_a_i(pa), .pin_a_oe_i(pa_oe), .pin_b_i(pb), .pin_b_oe_i(pb_oe),
        .bit_clk_o(bclk), .frame_sync_o(fsync), .res_a_o(res_a), .res_b_o(res_b), .slot_done_o(done));
    // ----------------------------------------
    // Checking
    // ----------------------------------------
    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results;
        if (failures == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // An empty queue yields unknown, so a surplus result never matches
    function automatic logic [32:0] pop();
        return exp_q.size() ? exp_q.pop_front() : 'x;
    endfunction
    // Every APB answer and every slot captured in a watched frame takes the oldest note
    always @(posedge clk_i) if (pready === 1'b1) check("apb", {pslverr, prdata}, pop());
    always @(done) if (watching) begin
        check("pin_a", res_a, pop());
        check("pin_b", res_b, pop());
    end
    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [32:0] e);
        int n;
        n = 0;
        exp_q.push_back(e);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1 && ++n < 20);
        if (pready !== 1'b1) begin
            failures++;
            results();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Write, then read back with reserved bits cleared
    task automatic set(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] m;
        m = idx == 8'h30 ? 32'h7 : idx == 8'h31 ? 32'h1 : 32'h7F;
        mir[idx] = d & m;
        apb(1'b1, {idx, 2'b00}, d, 33'h0);
        apb(1'b0, {idx, 2'b00}, 32'h0, {1'b0, d & m});
    endtask
    // Owner of a slot on one pin, ch5 first
    function automatic logic [32:0] pin_exp(input int s, input int pin);
        logic [7:0] c;
        logic [31:0] w;
        for (int ch = 5; ch < 8; ch++) begin
            c = mir[29 + ch][7:0];
            w = ch == 5 ? (c[5] ? loop1 : echo1) : ch == 6 ? (c[5] ? loop2 : echo2)
                : (c[5] ? {bat, temp} : {echo1[31:16], echo2[31:16]});
            if (c[4:0] == s && (c[6] ^ c[5]) && mir[48][ch - 5] == pin) return {1'b1, w};
        end
        return 33'h0;
    endfunction
    // Off-phase start keeps link edges away from the clock edge
    task automatic frame(input logic i2s, input logic watch);
        watching = watch;
        #3;
        for (int s = 0; s < 32 && watch; s++) begin
            exp_q.push_back(pin_exp(s, 0));
            exp_q.push_back(pin_exp(s, 1));
        end
        i_host.run_frame(i2s);
        @(posedge clk_i);
    endtask
    initial forever #5 clk_i = !clk_i;
    // Main sequence: reset values, refusals, then four configurations on the link
    initial begin
        void'($urandom(32'h8123));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        apb(1'b0, 10'h088, 32'h0, 33'h4);
        apb(1'b0, 10'h08C, 32'h0, 33'h5);
        apb(1'b0, 10'h090, 32'h0, 33'h6);
        apb(1'b0, 10'h0C8, 32'h0, 33'h0);
        apb(1'b0, 10'h089, 32'h0, 33'h1_0000_0000);
        apb(1'b1, 10'h3FC, 32'hFFFF_FFFF, 33'h1_0000_0000);
        for (int c = 0; c < 4; c++) begin
            foreach (idx_t[j]) if (c > 0) set(idx_t[j], {24'h0, cfg_t[c][j]});
            @(posedge clk_i);
            {loop1, loop2, echo1, echo2, bat, temp} <= {$urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
            if (c == 3) frame(1'b1, 1'b0);
            frame(c == 3, 1'b1);
        end
        check("queue", 33'(exp_q.size()), 33'h0);
        results();
    end
endmodule
